// ### hdl/pc_stack_pkg.sv
// Package: constants and carriers for program-flow and indirect addressing
package pc_stack_pkg;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int LATCH_W = 5;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int IND_ADDR_W = 9;
  localparam int OPERAND_W = 11;
  // Register byte addresses on APB
  localparam logic [7:0] REG_PC_LOW = 8'h00;
  localparam logic [7:0] REG_PC_HIGH_LATCH = 8'h04;
  localparam logic [7:0] REG_IND_POINTER = 8'h08;
  localparam logic [7:0] REG_IND_DATA = 8'h0C;
  localparam logic [7:0] REG_BANK = 8'h10;
  localparam logic [7:0] REG_PC_FULL = 8'h14;
  // Reset values
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;
  // Field positions and the self-select read value
  localparam int JUMP_HI_LSB = 3;
  localparam int PAGE_LSB = 11;
  localparam logic [DATA_W-1:0] SELF_READ = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_STEP = 3'h1,
    OP_JUMP = 3'h2,
    OP_CALL = 3'h3,
    OP_RETURN = 3'h4,
    OP_INTERRUPT = 3'h5
  } flow_op_e;

  typedef struct packed {
    flow_op_e op;
    logic [OPERAND_W-1:0] operand;
  } flow_req_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [DATA_W-1:0] wdata;
  } ind_req_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [IND_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_s;
endpackage

// ### hdl/program_counter_stack_indirect.sv
// Program counter, return stack and indirect addressing logic
//
// The APB slave port and the placing of the registers were decided locally.
module program_counter_stack_indirect
  import pc_stack_pkg::*;
#(
  parameter logic [PC_W-1:0] INT_VECTOR = 13'h0004
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire flow_req_s flow_req,
  input wire ind_req_s ind_req,
  output logic [PC_W-1:0] pc,
  output mem_req_s mem_req,
  input wire logic [DATA_W-1:0] mem_rdata,
  output logic [DATA_W-1:0] ind_rdata
);

  logic [LATCH_W-1:0] pc_high_latch;
  logic [DATA_W-1:0] indirect_pointer;
  logic indirect_bank_bit;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [SP_W-1:0] sp;
  logic [PC_W-1:0] next_pc;

  // APB decode
  wire logic apb_access = psel && penable;
  wire logic apb_wr = apb_access && pwrite;
  wire logic apb_rd = apb_access && !pwrite;
  wire logic hit_pcl = paddr == REG_PC_LOW;
  wire logic hit_lat = paddr == REG_PC_HIGH_LATCH;
  wire logic hit_fsr = paddr == REG_IND_POINTER;
  wire logic hit_ind = paddr == REG_IND_DATA;
  wire logic hit_bank = paddr == REG_BANK;
  // Full-pc offset stays unmapped so the upper bits remain hidden
  wire logic mapped = hit_pcl | hit_lat | hit_fsr | hit_ind |
                      hit_bank;
  wire logic wr_pcl = apb_wr && hit_pcl;

  // Indirect addressing
  wire logic [IND_ADDR_W-1:0] ind_addr =
    {indirect_bank_bit, indirect_pointer};
  wire logic ind_self = indirect_pointer == REG_IND_DATA; // self-select
  wire logic sw_ind = apb_access && hit_ind;
  wire logic ind_go = ind_req.valid | sw_ind;
  wire logic ind_wr = ind_req.valid ? ind_req.write : pwrite;
  wire logic [DATA_W-1:0] ind_wd =
    ind_req.valid ? ind_req.wdata : pwdata[DATA_W-1:0];
  wire logic [DATA_W-1:0] ind_value =
    ind_self ? SELF_READ : mem_rdata;

  // Flow control
  wire logic [PC_W-1:0] pc_inc = pc + 13'h0001;
  wire logic do_push = flow_req.op == OP_CALL ||
                       flow_req.op == OP_INTERRUPT;
  wire logic do_pop = flow_req.op == OP_RETURN;
  wire logic [SP_W-1:0] sp_top = sp - 3'h1;
  wire logic [PC_W-1:0] jump_target =
    {pc_high_latch[4:JUMP_HI_LSB], flow_req.operand};

  // Next program counter; low-byte write has priority
  always_comb begin
    next_pc = pc;
    if (wr_pcl) begin
      next_pc = {pc_high_latch, pwdata[DATA_W-1:0]};
    end else begin
      case (flow_req.op)
        OP_STEP: next_pc = pc_inc;
        OP_JUMP, OP_CALL: next_pc = jump_target;
        OP_RETURN: next_pc = stack_mem[sp_top];
        OP_INTERRUPT: next_pc = INT_VECTOR;
        default: next_pc = pc;
      endcase
    end
  end

  // Program counter register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pc <= PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // Stack pointer wraps with no status flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sp <= 3'h0;
    end else if (do_push) begin
      sp <= sp + 3'h1;
    end else if (do_pop) begin
      sp <= sp_top;
    end
  end

  // Stack entries; one per level
  for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
    always_ff @(posedge clk) begin
      if (do_push && sp == SP_W'(i)) begin
        stack_mem[i] <= (flow_req.op == OP_CALL) ? pc_inc : pc;
      end
    end
  end

  // Software registers; stack actions never touch the latch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pc_high_latch <= LATCH_RESET;
      indirect_pointer <= BYTE_RESET;
      indirect_bank_bit <= 1'b0;
    end else begin
      if (apb_wr && hit_lat) begin
        pc_high_latch <= pwdata[LATCH_W-1:0];
      end
      if (apb_wr && hit_fsr) begin
        indirect_pointer <= pwdata[DATA_W-1:0];
      end
      if (apb_wr && hit_bank) begin
        indirect_bank_bit <= pwdata[0];
      end
    end
  end

  // Memory request toward data space; self-write suppressed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_req <= '0;
      ind_rdata <= BYTE_RESET;
    end else begin
      mem_req.valid <= ind_go && !(ind_wr && ind_self);
      mem_req.write <= ind_wr && !ind_self;
      mem_req.addr <= ind_addr;
      mem_req.wdata <= ind_wd;
      if (ind_go && !ind_wr) begin
        ind_rdata <= ind_value;
      end
    end
  end

  // APB read data and ready
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= 32'h0000_0000;
        if (hit_pcl) prdata <= {24'h000000, pc[DATA_W-1:0]};
        if (hit_lat) prdata <= {27'h0000000, pc_high_latch};
        if (hit_fsr) prdata <= {24'h000000, indirect_pointer};
        if (hit_ind) prdata <= {24'h000000, ind_value};
        if (hit_bank) prdata <= {31'h00000000, indirect_bank_bit};
      end
    end
  end

  // Assertions
  a_reset_pc_zero: assert property (@(posedge clk)
    $rose(reset) |=> pc == PC_RESET) else $error("pc not cleared");
  a_pcl_load: assert property (@(posedge clk) disable iff (reset)
    wr_pcl |=> pc == {$past(pc_high_latch), $past(pwdata[7:0])})
    else $error("low byte write bad");
  a_jump_target: assert property (@(posedge clk) disable iff (reset)
    !wr_pcl && flow_req.op == OP_JUMP |=>
    pc == {$past(pc_high_latch[4:3]), $past(flow_req.operand)})
    else $error("jump target bad");
  a_latch_stable: assert property (@(posedge clk) disable iff (reset)
    (do_push || do_pop) && !(apb_wr && hit_lat) |=> $stable(pc_high_latch))
    else $error("latch changed by stack");
  // Call and return steps taken by the flow logic
  sequence s_call_taken;
    !wr_pcl && flow_req.op == OP_CALL;
  endsequence
  sequence s_return_taken;
    !wr_pcl && flow_req.op == OP_RETURN;
  endsequence
  a_call_return: assert property (@(posedge clk) disable iff (reset)
    s_call_taken ##1 s_return_taken |=> pc == $past(pc, 2) + 13'h0001)
    else $error("return address bad");
  a_sp_wrap: assert property (@(posedge clk) disable iff (reset)
    do_push |=> sp == $past(sp) + 3'h1) else $error("push ptr");
  a_pop_ptr: assert property (@(posedge clk) disable iff (reset)
    do_pop |=> sp == $past(sp) - 3'h1) else $error("pop ptr");
  a_self_write: assert property (@(posedge clk) disable iff (reset)
    ind_go && ind_wr && ind_self |=> !mem_req.valid)
    else $error("self write reached memory");
  a_self_read: assert property (@(posedge clk) disable iff (reset)
    ind_go && !ind_wr && ind_self |=> ind_rdata == SELF_READ)
    else $error("self read not zero");
  a_ind_addr: assert property (@(posedge clk) disable iff (reset)
    ind_go |=> mem_req.addr == {$past(indirect_bank_bit),
    $past(indirect_pointer)}) else $error("indirect addr");
  // Step moves to the next address
  a_step_next: assert property (@(posedge clk) disable iff (reset)
    !wr_pcl && flow_req.op == OP_STEP |=> pc == $past(pc) + 13'h0001)
    else $error("step bad");
  // Call target built like a jump
  a_call_target: assert property (@(posedge clk) disable iff (reset)
    s_call_taken |=> pc == {$past(pc_high_latch[4:3]), $past(flow_req.operand)})
    else $error("call target bad");
  // Interrupt vectoring lands on the vector
  a_int_target: assert property (@(posedge clk) disable iff (reset)
    !wr_pcl && flow_req.op == OP_INTERRUPT |=> pc == INT_VECTOR)
    else $error("vector bad");
  // Call stores the return address
  a_call_push: assert property (@(posedge clk) disable iff (reset)
    flow_req.op == OP_CALL |=> stack_mem[$past(sp)] == $past(pc) + 13'h0001)
    else $error("call push bad");
  // Interrupt stores the interrupted address
  a_int_push: assert property (@(posedge clk) disable iff (reset)
    flow_req.op == OP_INTERRUPT |=> stack_mem[$past(sp)] == $past(pc))
    else $error("interrupt push bad");
  // Return loads the top entry
  a_pop_value: assert property (@(posedge clk) disable iff (reset)
    s_return_taken |=> pc == $past(stack_mem[sp_top]))
    else $error("pop value bad");
  // Idle cycle keeps the program counter
  a_idle_pc: assert property (@(posedge clk) disable iff (reset)
    !wr_pcl && flow_req.op == OP_NONE |=> $stable(pc))
    else $error("pc moved when idle");
  // Only a latch write changes the latch
  a_latch_hold: assert property (@(posedge clk) disable iff (reset)
    !(apb_wr && hit_lat) |=> $stable(pc_high_latch))
    else $error("latch changed");
  // Latch write stores five bits
  a_latch_write: assert property (@(posedge clk) disable iff (reset)
    apb_wr && hit_lat |=> pc_high_latch == $past(pwdata[4:0]))
    else $error("latch write bad");
  // Stack pointer moves only on push or pop
  a_ptr_hidden: assert property (@(posedge clk) disable iff (reset)
    !do_push && !do_pop |=> $stable(sp))
    else $error("pointer moved");
  // Pop from empty wraps silently
  a_wrap_pop: assert property (@(posedge clk) disable iff (reset)
    do_pop && sp == 3'h0 |=> sp == 3'h7)
    else $error("pop wrap bad");
  // Indirect access reaches memory unless self-write
  a_mem_valid: assert property (@(posedge clk) disable iff (reset)
    ind_go && !(ind_wr && ind_self) |=> mem_req.valid)
    else $error("memory request missing");
  // No access, no memory request
  a_mem_idle: assert property (@(posedge clk) disable iff (reset)
    !ind_go |=> !mem_req.valid)
    else $error("spurious memory request");
  // Write data carried to memory
  a_mem_wdata: assert property (@(posedge clk) disable iff (reset)
    ind_go && ind_wr |=> mem_req.wdata == $past(ind_wd))
    else $error("memory wdata bad");
  // Read returns the memory value
  a_mem_read: assert property (@(posedge clk) disable iff (reset)
    ind_go && !ind_wr && !ind_self |=> ind_rdata == $past(mem_rdata))
    else $error("indirect read bad");
  // Self access never writes memory
  a_self_nowrite: assert property (@(posedge clk) disable iff (reset)
    ind_go && ind_self |=> !mem_req.write)
    else $error("self write flagged");
  // Ready answers every setup cycle
  a_pready_pulse: assert property (@(posedge clk) disable iff (reset)
    psel && !penable |=> pready)
    else $error("ready missing");
  // Ready stands a single cycle
  a_pready_drop: assert property (@(posedge clk) disable iff (reset)
    pready |=> !pready)
    else $error("ready held");
  // Unmapped offsets report an error
  a_slverr_map: assert property (@(posedge clk) disable iff (reset)
    psel && !penable && !mapped |=> pslverr)
    else $error("unmapped without error");
  // Low byte readable
  a_low_read: assert property (@(posedge clk) disable iff (reset)
    psel && !penable && !pwrite && hit_pcl |=>
    prdata == {24'h000000, $past(pc[7:0])})
    else $error("low byte read bad");
  // Unmapped reads expose nothing, upper pc bits included
  a_upper_hidden: assert property (@(posedge clk) disable iff (reset)
    psel && !penable && !pwrite && !mapped |=> prdata == 32'h0000_0000)
    else $error("hidden data read");
endmodule

// ### dv/program_counter_stack_indirect_tb_top.sv
// Bench: program counter, return stack and indirect access
module program_counter_stack_indirect_tb_top
  import pc_stack_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [PC_W-1:0] IV = 13'h0ABC;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  flow_req_s flow_req;
  ind_req_s ind_req;
  mem_req_s mem_req;
  logic [PC_W-1:0] pc;
  logic [DATA_W-1:0] mem_rdata, ind_rdata;
  int m_pc, m_lat, sp, miscompares, n_compared, p;
  int stk[8];

  program_counter_stack_indirect #(.INT_VECTOR(IV)) uut (.clk(clk),
    .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flow_req(flow_req), .ind_req(ind_req), .pc(pc),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .ind_rdata(ind_rdata));

  // Clock at 100 MHz
  always #5 clk = ~clk;

  // Verdict and end of run
  task end_of_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  // APB master: setup, access, wait for pready
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20)
      miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One flow op, model update, then pc compare
  task flow(input flow_op_e op, input int x);
    @(posedge clk);
    flow_req <= '{op, x[10:0]};
    @(posedge clk);
    flow_req <= '{OP_NONE, 11'h000};
    if (op == OP_CALL || op == OP_INTERRUPT) begin
      stk[sp] = (op == OP_CALL) ? (m_pc + 1) % 8192 : m_pc;
      sp = (sp + 1) % 8;
    end
    if (op == OP_STEP)
      m_pc = (m_pc + 1) % 8192;
    if (op == OP_JUMP || op == OP_CALL)
      m_pc = ((m_lat & 24) << 8) | x;
    if (op == OP_INTERRUPT)
      m_pc = IV;
    if (op == OP_RETURN) begin
      sp = (sp + 7) % 8;
      m_pc = stk[sp];
    end
    #1 chk("pc", m_pc, pc);
  endtask

  // Core indirect access and memory request compare
  task ind(input logic w, input int bk);
    logic [7:0] d, md;
    d = $urandom;
    md = $urandom;
    @(posedge clk);
    ind_req <= '{1'b1, w, d};
    mem_rdata <= md;
    @(posedge clk);
    ind_req <= '0;
    #1;
    if (w)
      chk("mem valid", p != 12, mem_req.valid);
    if (p != 12) begin
      chk("mem addr", bk * 256 + p, mem_req.addr);
      chk("mem write", w, mem_req.write);
      if (w)
        chk("mem wdata", d, mem_req.wdata);
    end
    if (!w)
      chk("ind rdata", (p == 12) ? 0 : md, ind_rdata);
  endtask

  // Watchdog
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end

  // Main sequence
  initial begin
    clk = 0;
    reset = 1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    flow_req = '0;
    ind_req = '0;
    mem_rdata = '0;
    {m_pc, sp, miscompares, n_compared} = '0;
    void'($urandom(48));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    #1 chk("pc reset", 0, pc);
    m_lat = $urandom_range(31);
    p = $urandom_range(255);
    apb(REG_PC_HIGH_LATCH, 1'b1, m_lat);
    apb(REG_PC_LOW, 1'b1, p);
    m_pc = (m_lat << 8) | p;
    #1 chk("pc load", m_pc, pc);
    apb(REG_PC_LOW, 1'b0, 0);
    chk("pc low", m_pc & 255, rd);
    m_lat = (m_lat + 1) % 32;
    apb(REG_PC_HIGH_LATCH, 1'b1, m_lat);
    apb(REG_PC_LOW, 1'b1, 32'h0000_00FF);
    m_pc = m_lat * 256 + 255;
    #1 chk("pc computed", m_pc, pc);
    $display("test pc_load done");
    for (int i = 0; i < 3; i++) begin
      flow(OP_JUMP, $urandom_range(2047));
      flow(OP_STEP, 0);
    end
    for (int i = 0; i < 10; i++)
      flow(OP_CALL, $urandom_range(2047));
    flow(OP_INTERRUPT, 0);
    for (int i = 0; i < 11; i++)
      flow(OP_RETURN, 0);
    apb(REG_PC_HIGH_LATCH, 1'b0, 0);
    chk("latch", m_lat, rd);
    // Call straight into return resumes after the call
    @(posedge clk);
    flow_req <= '{OP_CALL, 11'h155};
    @(posedge clk);
    flow_req <= '{OP_RETURN, 11'h000};
    @(posedge clk);
    flow_req <= '{OP_NONE, 11'h000};
    stk[sp] = (m_pc + 1) % 8192;
    m_pc = stk[sp];
    #1 chk("pc call ret", m_pc, pc);
    $display("test stack done");
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 12 : $urandom_range(255);
      apb(REG_IND_POINTER, 1'b1, p);
      apb(REG_BANK, 1'b1, i % 2);
      ind(1'b1, i % 2);
      ind(1'b0, i % 2);
      apb(REG_IND_DATA, 1'b1, p + 1);
      #1 chk("port write", p != 12, mem_req.valid);
      apb(REG_IND_DATA, 1'b0, 0);
      chk("port read", (p == 12) ? 0 : mem_rdata, rd);
    end
    apb(8'h40, 1'b0, 0);
    chk("slverr", 1, er);
    apb(REG_PC_FULL, 1'b0, 0);
    chk("upper hidden", 0, rd);
    // Mid-run reset clears pc and latch again
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1 chk("pc rerun", 0, pc);
    apb(REG_PC_HIGH_LATCH, 1'b0, 0);
    chk("latch rerun", 0, rd);
    $display("test indirect done");
    end_of_test();
  end
endmodule
